// File: hdl/csbp_pkg.sv
package csbp_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] BUF_BASE_ADDR = 12'hF90;
    localparam logic [11:0] CTRL_ONE_ADDR = 12'hF98;
    localparam logic [11:0] CTRL_TWO_ADDR = 12'hF99;
    localparam logic [11:0] STATUS_ADDR = 12'hF99;
    localparam logic [8:0] BUF_PAGE = 9'h1F2;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int START_POS = 7;
    localparam int ABORT_POS = 6;
    localparam int MODE_LSB = 3;
    localparam int CKSEL_LSB = 0;
    localparam int WAIT_LSB = 3;
    localparam int COUNT_LSB = 0;
    localparam int BUSY_POS = 7;
    localparam int SHIFT_POS = 6;
    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [4:0] CTRL_TWO_RST = 5'h00;

    // ----------------------------------------------------------------
    // Mode and clock codes
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_TX8 = 3'h0;
    localparam logic [2:0] MODE_TX4 = 3'h2;
    localparam logic [2:0] MODE_FDX8 = 3'h4;
    localparam logic [2:0] MODE_RX8 = 3'h5;
    localparam logic [2:0] MODE_RX4 = 3'h6;
    localparam logic [2:0] CKSEL_SLOWEST = 3'h0;
    localparam logic [2:0] CKSEL_EXT = 3'h7;

    // ----------------------------------------------------------------
    // Timing: divider masks, half periods in clock cycles minus one
    // ----------------------------------------------------------------
    localparam logic [12:0] HALF_MASK_0 = 13'h0FFF;
    localparam logic [12:0] HALF_MASK_1 = 13'h007F;
    localparam logic [12:0] HALF_MASK_2 = 13'h003F;
    localparam logic [12:0] HALF_MASK_3 = 13'h001F;
    localparam logic [12:0] HALF_MASK_4 = 13'h000F;
    localparam logic [12:0] HALF_MASK_5 = 13'h0007;
    localparam logic [3:0] LF_HALF_MASK = 4'hF;
    localparam logic [7:0] GAP_HALVES_PER_WORD = 8'h10;
    localparam logic [7:0] DUMMY_BYTE = 8'hFF;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {PH_IDLE, PH_SHIFT, PH_GAP, PH_WAIT} csbp_phase_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } csbp_req_t;

    typedef struct packed {
        csbp_phase_t phase;
        logic [7:0] ctrl_one;
        logic [4:0] ctrl_two;
        logic [7:0][7:0] buffer;
        logic [7:0] tx_shift;
        logic [7:0] rx_shift;
        logic [2:0] bit_idx;
        logic [2:0] word_idx;
        logic [12:0] div_cnt;
        logic [3:0] lf_cnt;
        logic [7:0] gap_cnt;
        logic busy;
        logic dummy;
        logic sck_prev;
        logic sck;
        logic sck_oe;
        logic so;
        logic irq;
        logic [7:0] rdata;
    } csbp_state_t;

endpackage

// File: hdl/csbp_top.sv
// Summary of operation
// - Frame wait (internal clock only) stretches an 8-bit frame to 1/2/4/8 words
// - Word count is field plus one
// - 4-bit mode: low nibble, zero high
// - Buffer walked from lowest address upward
// - Word count kept after block ends
// - Count register write-only, upper bits ignored
// - Status: bit7 transfer busy, bit6 shifting
// - Busy drops at end or on abort
// - Clock select picks divider or external
// - Internal clock driven out, high at start
// - Transmit bits change on falling edge
// - Receive bits sampled on rising edge
// - Words shift least significant bit first
// - Interrupt after programmed word count done
// - Count rewritable during internal automatic wait
// - Next word loaded as LSB leaves
// - Internal clock waits until buffer touched
// - Buffer write releases send/duplex wait, buffer read releases receive wait
// - Stop finishes current word, abort immediate
// - External clock, start left set: dummy then end
// - Control one: start, abort, mode, clock
// - Mode codes decode tx, rx, full duplex
module csbp_top
    import csbp_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire csbp_req_t REG_REQ_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic LF_TICK_I,
    input wire logic ALT_DIV_SEL_I,
    input wire logic SLOW_MODE_I,
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE_O,
    output logic SO_O,
    input wire logic SI_I,
    output logic INT_O
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Half-period mask of the fast divider for a clock select code
    function automatic logic [12:0] half_mask(input logic [2:0] sel);
        case (sel)
            3'h0: half_mask = HALF_MASK_0;
            3'h1: half_mask = HALF_MASK_1;
            3'h2: half_mask = HALF_MASK_2;
            3'h3: half_mask = HALF_MASK_3;
            3'h4: half_mask = HALF_MASK_4;
            default: half_mask = HALF_MASK_5;
        endcase
    endfunction

    // Extra half periods inserted after each word except the last of the block
    function automatic logic [7:0] gap_halves(input logic [1:0] code);
        case (code)
            2'h1: gap_halves = GAP_HALVES_PER_WORD;
            2'h2: gap_halves = 8'(3 * GAP_HALVES_PER_WORD);
            2'h3: gap_halves = 8'(7 * GAP_HALVES_PER_WORD);
            default: gap_halves = 8'h00;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Decoded controls
    // ----------------------------------------------------------------
    csbp_state_t r;
    csbp_state_t next_r;
    logic [2:0] mode;
    logic [2:0] cksel;
    logic [1:0] wait_code;
    logic [2:0] last_word;
    logic is_tx;
    logic is_rx;
    logic four_bit;
    logic ext_clk;
    logic start_set;
    logic buf_hit;
    logic buf_wr;
    logic buf_rd;
    logic tick;
    logic fall;
    logic rise;
    logic release_wait;
    logic [7:0] rx_next;
    logic [7:0] load_byte;

    // Control register fields
    assign mode = r.ctrl_one[MODE_LSB +: 3];
    assign cksel = r.ctrl_one[CKSEL_LSB +: 3];
    assign start_set = r.ctrl_one[START_POS];
    assign wait_code = r.ctrl_two[WAIT_LSB +: 2];
    assign last_word = r.ctrl_two[COUNT_LSB +: 3];
    assign ext_clk = (cksel == CKSEL_EXT);

    // Mode decode, reserved codes neither send nor receive
    assign is_tx = (mode == MODE_TX8) || (mode == MODE_TX4) || (mode == MODE_FDX8);
    assign is_rx = (mode == MODE_RX8) || (mode == MODE_RX4) || (mode == MODE_FDX8);
    assign four_bit = (mode == MODE_TX4) || (mode == MODE_RX4);

    // Buffer access decode
    assign buf_hit = (REG_REQ_I.addr[11:3] == BUF_PAGE);
    assign buf_wr = REG_REQ_I.wr && buf_hit;
    assign buf_rd = REG_REQ_I.rd && buf_hit;

    // Wait release: reads free receive, writes free send and duplex
    assign release_wait = is_tx ? buf_wr : buf_rd;

    // Internal half-period tick; slow source counts low-frequency ticks
    always_comb begin
        if (cksel == CKSEL_SLOWEST && (ALT_DIV_SEL_I || SLOW_MODE_I)) begin
            tick = LF_TICK_I && (r.lf_cnt == LF_HALF_MASK);
        end else begin
            tick = ((r.div_cnt & half_mask(cksel)) == half_mask(cksel));
        end
    end

    // Serial clock edges from the selected source
    assign fall = ext_clk ? (r.sck_prev && !SCK_I) : (tick && r.sck);
    assign rise = ext_clk ? (!r.sck_prev && SCK_I) : (tick && !r.sck);

    // Incoming byte after this rising edge, LSB arrives first
    assign rx_next = {SI_I, r.rx_shift[7:1]};
    assign load_byte = r.dummy ? DUMMY_BYTE : r.buffer[r.word_idx];

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.irq = 1'b0;
        next_r.rdata = 8'h00;
        next_r.sck_prev = SCK_I;
        next_r.sck_oe = !ext_clk;

        // Dividers run only while the clock is live
        if (r.phase == PH_SHIFT || r.phase == PH_GAP) begin
            next_r.div_cnt = r.div_cnt + 13'h0001;
            if (LF_TICK_I) begin
                next_r.lf_cnt = r.lf_cnt + 4'h1;
            end
        end

        // Shift engine
        case (r.phase)
            PH_IDLE: begin
                next_r.sck = 1'b1;
            end
            PH_SHIFT: begin
                // Dummy word not begun and start now clear: the block is over
                if (r.dummy && !start_set && r.bit_idx == 3'h0 && r.sck_prev && SCK_I) begin
                    next_r.phase = PH_IDLE;
                    next_r.busy = 1'b0;
                    next_r.dummy = 1'b0;
                end
                if (fall) begin
                    if (!ext_clk) begin
                        next_r.sck = 1'b0;
                    end
                    if (r.bit_idx == 3'h0) begin
                        next_r.tx_shift = load_byte >> 1;
                        next_r.so = is_tx ? load_byte[0] : 1'b1;
                    end else begin
                        next_r.tx_shift = r.tx_shift >> 1;
                        next_r.so = is_tx ? r.tx_shift[0] : 1'b1;
                    end
                end
                if (rise) begin
                    if (!ext_clk) begin
                        next_r.sck = 1'b1;
                    end
                    next_r.rx_shift = rx_next;
                    next_r.bit_idx = r.bit_idx + 3'h1;
                    if (r.bit_idx == (four_bit ? 3'h3 : 3'h7)) begin
                        next_r.bit_idx = 3'h0;
                        if (is_rx && !r.dummy) begin
                            next_r.buffer[r.word_idx] = four_bit ?
                                {4'h0, rx_next[7:4]} : rx_next;
                        end
                        if (r.dummy) begin
                            next_r.phase = PH_IDLE;
                            next_r.busy = 1'b0;
                            next_r.dummy = 1'b0;
                        end else if (r.word_idx == last_word) begin
                            next_r.irq = 1'b1;
                            next_r.word_idx = 3'h0;
                            if (!start_set) begin
                                next_r.phase = PH_IDLE;
                                next_r.busy = 1'b0;
                            end else if (ext_clk) begin
                                next_r.dummy = 1'b1;
                            end else begin
                                next_r.phase = PH_WAIT;
                            end
                        end else if (!start_set) begin
                            next_r.phase = PH_IDLE;
                            next_r.busy = 1'b0;
                        end else begin
                            next_r.word_idx = r.word_idx + 3'h1;
                            if (!ext_clk && gap_halves(wait_code) != 8'h00) begin
                                next_r.phase = PH_GAP;
                                next_r.gap_cnt = gap_halves(wait_code) - 8'h01;
                            end
                        end
                    end
                end
            end
            PH_GAP: begin
                // Clock held high for the rest of the frame
                if (tick) begin
                    if (r.gap_cnt == 8'h00) begin
                        next_r.phase = PH_SHIFT;
                    end else begin
                        next_r.gap_cnt = r.gap_cnt - 8'h01;
                    end
                end
            end
            PH_WAIT: begin
                // Clock stopped high until software catches up
                next_r.div_cnt = 13'h0000;
                next_r.lf_cnt = 4'h0;
                if (!start_set) begin
                    next_r.phase = PH_IDLE;
                    next_r.busy = 1'b0;
                end else if (release_wait) begin
                    next_r.phase = PH_SHIFT;
                end
            end
            default: begin
                next_r.phase = PH_IDLE;
            end
        endcase

        // Register reads, data valid the cycle after the strobe
        if (REG_REQ_I.rd) begin
            if (buf_hit) begin
                next_r.rdata = r.buffer[REG_REQ_I.addr[2:0]];
            end else if (REG_REQ_I.addr == STATUS_ADDR) begin
                next_r.rdata[BUSY_POS] = r.busy;
                next_r.rdata[SHIFT_POS] = (r.phase == PH_SHIFT);
            end
        end

        // Buffer writes from software
        if (buf_wr) begin
            next_r.buffer[REG_REQ_I.addr[2:0]] = REG_REQ_I.wdata;
        end

        // Count register accepted any time, upper bits dropped
        if (REG_REQ_I.wr && REG_REQ_I.addr == CTRL_TWO_ADDR) begin
            next_r.ctrl_two = REG_REQ_I.wdata[4:0];
        end

        // Control one: abort wins over start; abort bit never stored
        if (REG_REQ_I.wr && REG_REQ_I.addr == CTRL_ONE_ADDR) begin
            next_r.ctrl_one = REG_REQ_I.wdata;
            next_r.ctrl_one[ABORT_POS] = 1'b0;
            if (REG_REQ_I.wdata[ABORT_POS]) begin
                next_r.phase = PH_IDLE;
                next_r.busy = 1'b0;
                next_r.dummy = 1'b0;
                next_r.sck = 1'b1;
                next_r.bit_idx = 3'h0;
                next_r.word_idx = 3'h0;
            end else if (REG_REQ_I.wdata[START_POS] && r.phase == PH_IDLE) begin
                next_r.phase = PH_SHIFT;
                next_r.busy = 1'b1;
                next_r.sck = 1'b1;
                next_r.bit_idx = 3'h0;
                next_r.word_idx = 3'h0;
                next_r.div_cnt = 13'h0000;
                next_r.lf_cnt = 4'h0;
                next_r.dummy = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            r <= '0;
            r.phase <= PH_IDLE;
            r.ctrl_one <= CTRL_ONE_RST;
            r.ctrl_two <= CTRL_TWO_RST;
            r.sck <= 1'b1;
            r.sck_prev <= 1'b1;
            r.sck_oe <= 1'b0;
            r.so <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign REG_RDATA_O = r.rdata;
    assign SCK_O = r.sck;
    assign SCK_OE_O = r.sck_oe;
    assign SO_O = r.so;
    assign INT_O = r.irq;

endmodule

// File: tb/csbp_monitor.sv
module csbp_monitor
    import csbp_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire csbp_req_t REG_REQ_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic SCK_O,
    input wire logic SCK_OE_O,
    input wire logic SO_O,
    input wire logic INT_O
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // Port relations
    // ----------------------------------------------------------------
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    rd_quiet_a: assert property (!$past(REG_REQ_I.rd) |-> REG_RDATA_O == 8'h00)
        else $error("read data outside its slot");
    status_bits_a: assert property (REG_REQ_I.rd && REG_REQ_I.addr == STATUS_ADDR
        |=> REG_RDATA_O[5:0] == 6'h00) else $error("status low bits set");
    ctrl_wo_a: assert property (REG_REQ_I.rd && REG_REQ_I.addr == CTRL_ONE_ADDR
        |=> REG_RDATA_O == 8'h00) else $error("control one readable");
    ext_clk_a: assert property (REG_REQ_I.wr && REG_REQ_I.addr == CTRL_ONE_ADDR
        && REG_REQ_I.wdata[2:0] == CKSEL_EXT |-> ##[1:2] !SCK_OE_O)
        else $error("clock pin driven in external mode");
    so_on_fall_a: assert property (SCK_OE_O && $changed(SO_O)
        && !$past(REG_REQ_I.wr) |-> $fell(SCK_O)) else $error("data moved off falling edge");
    low_half_a: assert property ($fell(SCK_O) |-> (!SCK_O)[*8])
        else $error("serial clock low phase too short");
    int_pulse_a: assert property (INT_O |=> !INT_O)
        else $error("interrupt longer than one cycle");
    int_rise_a: assert property (INT_O && SCK_OE_O
        |-> SCK_O && (!$past(SCK_O) || !$past(SCK_O, 2))) else $error("interrupt off clock rise");
    sck_drive_a: assert property ($changed(SCK_O) |-> SCK_OE_O)
        else $error("clock toggles while not driven");
endmodule

bind csbp_top csbp_monitor csbp_monitor_inst (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .REG_REQ_I(REG_REQ_I), .REG_RDATA_O(REG_RDATA_O), .SCK_O(SCK_O), .SCK_OE_O(SCK_OE_O),
    .SO_O(SO_O), .INT_O(INT_O));

// File: tb/csbp_peer.sv
module csbp_peer (
    input wire logic clk_i,
    input wire logic sck_i,
    input wire logic so_i,
    input wire logic [3:0] width_i,
    input wire logic [7:0] tx_i,
    output logic si_o = 1'b1,
    output logic done_o = 1'b0,
    output logic [7:0] rx_o = 8'h00
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // Far-side shift registers
    // ----------------------------------------------------------------
    logic prev = 1'b1;
    logic [7:0] sh = 8'h00;
    logic [3:0] cnt = 4'h0;

    // Capture on rise, present next bit on fall
    always @(posedge clk_i) begin
        prev <= sck_i;
        done_o <= 1'b0;
        if (sck_i && !prev) begin
            sh = {so_i, sh[7:1]};
            cnt = cnt + 4'h1;
            if (cnt == width_i) begin
                rx_o <= (width_i == 4'h4) ? {4'h0, sh[7:4]} : sh;
                done_o <= 1'b1;
                cnt = 4'h0;
            end
        end else if (!sck_i && prev) begin
            si_o <= tx_i[cnt[2:0]];
        end
    end
endmodule

// File: tb/csbp_top_tb_top.sv
module csbp_top_tb_top
    import csbp_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // Clock, design and far side
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ext_sck = 1'b1;
    logic rd_d = 1'b0;
    logic ser_on = 1'b1;
    logic sck_o, sck_oe, so, si, int_o, done;
    logic [3:0] pw = 4'h8;
    logic [7:0] ptx = 8'h00;
    logic [7:0] rdata, rx, r, c;
    logic [7:0] b[2];
    logic [7:0] exp_q[$];
    logic [7:0] ser_q[$];
    csbp_req_t req = '0;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int int_cnt = 0;
    int n0;
    integer seed = 25822;
    wire line = sck_oe ? sck_o : ext_sck;

    always #12.5 clk = ~clk;

    csbp_top csbp_top_inst (.CLK_I(clk), .SYS_RST_I(rst), .REG_REQ_I(req), .REG_RDATA_O(rdata),
        .LF_TICK_I(1'b0), .ALT_DIV_SEL_I(1'b0), .SLOW_MODE_I(1'b0), .SCK_I(line),
        .SCK_O(sck_o), .SCK_OE_O(sck_oe), .SO_O(so), .SI_I(si), .INT_O(int_o));
    csbp_peer csbp_peer_inst (.clk_i(clk), .sck_i(line), .so_i(so), .width_i(pw), .tx_i(ptx),
        .si_o(si), .done_o(done), .rx_o(rx));

    // ----------------------------------------------------------------
    // Result watching
    // ----------------------------------------------------------------
    // Read slot, interrupt count and hang limit
    always @(posedge clk) begin
        rd_d <= req.rd;
        cycles <= cycles + 1;
        if (int_o === 1'b1) int_cnt <= int_cnt + 1;
        if (cycles == 20000) begin
            num_errors++;
            $display("Error %0t: run hung", $time);
            wrap_up();
        end
    end

    // Oldest note against each read answer and each word the peer took while ser_on is set
    always @(negedge clk) begin
        if (rd_d) begin
            comparisons++;
            if (rdata !== exp_q[0]) begin
                num_errors++;
                $display("Error %0t: read %h want %h", $time, rdata, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
        if (done && ser_on) begin
            comparisons++;
            if (ser_q.size() == 0 || rx !== ser_q[0]) begin
                num_errors++;
                $display("Error %0t: serial word %h", $time, rx);
            end
            if (ser_q.size() > 0) void'(ser_q.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // Bus tasks and stimulus
    // ----------------------------------------------------------------
    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [11:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
    endtask

    task automatic wait_int();
        int n;
        n = int_cnt;
        repeat (3000) begin
            @(posedge clk);
            if (int_cnt != n) return;
        end
        num_errors++;
        $display("Error %0t: no block interrupt", $time);
    endtask

    task automatic wrap_up();
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        bus_rd(STATUS_ADDR, 8'h00);
        bus_rd(CTRL_ONE_ADDR, 8'h00);
        bus_rd(12'h100, 8'h00);
        bus_wr(CTRL_TWO_ADDR, 8'h01);
        for (int i = 0; i < 2; i++) begin
            b[i] = 8'($random(seed));
            bus_wr(BUF_BASE_ADDR + 12'(i), b[i]);
        end
        ser_q = '{b[0], b[1], b[0]};
        bus_wr(CTRL_ONE_ADDR, 8'h85);
        bus_rd(STATUS_ADDR, 8'hC0);
        wait_int();
        bus_rd(STATUS_ADDR, 8'h80);
        bus_wr(CTRL_TWO_ADDR, 8'h00);
        bus_wr(BUF_BASE_ADDR + 12'h5, 8'h5A);
        wait_int();
        bus_wr(CTRL_ONE_ADDR, 8'h05);
        bus_rd(STATUS_ADDR, 8'h00);
        r = 8'($random(seed));
        bus_wr(CTRL_ONE_ADDR, 8'h15);
        bus_wr(BUF_BASE_ADDR, r);
        ser_q.push_back({4'h0, r[3:0]});
        pw <= 4'h4;
        bus_wr(CTRL_ONE_ADDR, 8'h95);
        wait_int();
        bus_wr(CTRL_ONE_ADDR, 8'h15);
        bus_rd(STATUS_ADDR, 8'h00);
        r = 8'($random(seed));
        c = 8'($random(seed));
        pw <= 4'h8;
        ptx <= c;
        bus_wr(CTRL_ONE_ADDR, 8'h25);
        bus_wr(BUF_BASE_ADDR, r);
        ser_q.push_back(r);
        bus_wr(CTRL_ONE_ADDR, 8'hA5);
        wait_int();
        bus_wr(CTRL_ONE_ADDR, 8'h25);
        bus_rd(BUF_BASE_ADDR, c);
        ser_on <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            r = 8'($random(seed));
            c = i ? 8'h35 : 8'h2D;
            ptx <= r;
            pw <= i ? 4'h4 : 4'h8;
            bus_wr(CTRL_ONE_ADDR, c);
            bus_wr(CTRL_ONE_ADDR, c | 8'h80);
            wait_int();
            bus_wr(CTRL_ONE_ADDR, c);
            bus_rd(BUF_BASE_ADDR, i ? {4'h0, r[3:0]} : r);
        end
        ser_on <= 1'b1;
        pw <= 4'h8;
        bus_wr(CTRL_ONE_ADDR, 8'h05);
        bus_wr(CTRL_ONE_ADDR, 8'h85);
        bus_wr(CTRL_ONE_ADDR, 8'hC5);
        bus_rd(STATUS_ADDR, 8'h00);
        r = 8'($random(seed));
        bus_wr(CTRL_ONE_ADDR, 8'h07);
        bus_wr(BUF_BASE_ADDR, r);
        ser_q.push_back(r);
        bus_wr(CTRL_ONE_ADDR, 8'h87);
        n0 = int_cnt;
        repeat (8) begin
            repeat (20) @(posedge clk);
            ext_sck <= 1'b0;
            repeat (20) @(posedge clk);
            ext_sck <= 1'b1;
        end
        bus_wr(CTRL_ONE_ADDR, 8'h07);
        bus_rd(STATUS_ADDR, 8'h00);
        repeat (2) @(posedge clk);
        comparisons++;
        if (int_cnt != n0 + 1) begin
            num_errors++;
            $display("Error %0t: external block interrupt count", $time);
        end
        if (ser_q.size() != 0 || exp_q.size() != 0) begin
            num_errors++;
            $display("Error %0t: expected results never seen", $time);
        end
        wrap_up();
    end
endmodule
